// >>> include/sspm_defs.svh
// Constants for the serial pin and select-mode block
// Assumes inclusion by bare name from the main module
`ifndef SSPM_DEFS_SVH
`define SSPM_DEFS_SVH

// ************************************************************
// Register map (word offsets, byte addresses)
// ************************************************************
`define SSPM_CTRL_OFF      4'h0
`define SSPM_DATA_OFF      4'h4
`define SSPM_CFG_OFF       4'h8

// ************************************************************
// Control register fields
// ************************************************************
`define SSPM_EN_BIT        0
`define SSPM_SELLO_BIT     2
`define SSPM_SELHI_BIT     3
`define SSPM_MODE_FAULT_FLAG_BIT      5
`define SSPM_MASTER_ENABLE_BIT_BIT     6
`define SSPM_DONE_BIT      7
`define SSPM_CTRL_RST      8'h04

// ************************************************************
// Timing and sizes
// ************************************************************
`define SSPM_DIV_RST       8'h01
`define SSPM_BITS          8

`endif

// >>> include/sspm_pkg.sv
// Types shared by the serial pin and select-mode block
// Assumes the defs header sits in the include path
package sspm_pkg;
    typedef enum logic [1:0] {
        SSPM_IDLE,
        SSPM_LOW,
        SSPM_HIGH
    } sspm_mst_e;

    typedef logic [7:0] sspm_byte_t;
endpackage

// >>> rtl/sspm_sync.sv
// Two-flop synchroniser for one pin level
// Assumes the pin is asynchronous to clk_i
`timescale 1ns/1ps
module sspm_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    input  wire logic rst_val_i,
    output logic      q_o
);
    logic meta_r;

    // Stage one is read only by stage two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= rst_val_i;
            q_o    <= rst_val_i;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

// >>> rtl/sspm_core.sv
// Full-duplex serial unit with Wishbone registers, mode 0 timing
// Assumes classic Wishbone master on clk_i; pins asynchronous
`timescale 1ns/1ps
`include "sspm_defs.svh"
module sspm_core
    import sspm_pkg::*;
#(
    parameter int BITS = `SSPM_BITS
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       cyc_i,
    input  wire logic       stb_i,
    input  wire logic       we_i,
    input  wire logic [3:0] adr_i,
    input  wire logic [3:0] sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic       mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe_o,
    input  wire logic       miso_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    input  wire logic       sck_i,
    output logic             sck_o,
    output logic             sck_oe_o,
    input  wire logic       sel_n_i,
    output logic             sel_n_o,
    output logic             sel_n_oe_o,
    output logic             sel_routed_o
);
    initial begin
        if (BITS != 8) $error("sspm_core serves 8-bit bytes only");
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic mosi_s;
    logic miso_s;
    logic sck_s;
    logic seln_s;

    sspm_sync u_mosi (.clk_i(clk_i), .rst_i(rst_i), .d_i(mosi_i),  .rst_val_i(1'b0), .q_o(mosi_s));
    sspm_sync u_miso (.clk_i(clk_i), .rst_i(rst_i), .d_i(miso_i),  .rst_val_i(1'b0), .q_o(miso_s));
    sspm_sync u_sck  (.clk_i(clk_i), .rst_i(rst_i), .d_i(sck_i),   .rst_val_i(1'b0), .q_o(sck_s));
    // Select resets to its idle high level so no false falling edge follows reset
    sspm_sync u_seln (.clk_i(clk_i), .rst_i(rst_i), .d_i(sel_n_i), .rst_val_i(1'b1), .q_o(seln_s));

    // ************************************************************
    // State
    // ************************************************************
    logic       en_r;
    logic       master_enable_bit_r;
    logic       mode_fault_flag_r;
    logic       done_r;
    logic [1:0] smode_r;
    logic [7:0] div_r;
    logic [7:0] divcnt_r;
    sspm_byte_t shift_r;
    sspm_byte_t rxbuf_r;
    sspm_byte_t txbuf_r;
    logic       txfull_r;
    logic [3:0] bitcnt_r;
    logic       sck_d_r;
    logic       seln_d_r;
    sspm_mst_e  mst_r;
    logic       rxbit_r;

    // Decoded modes
    logic three_wire;
    logic slave_sel;
    logic sck_rise;
    logic sck_fall;
    logic sel_fall;
    logic fault;
    logic wr;
    logic rd_data;
    logic byte_end;
    logic tick;

    assign three_wire = (smode_r == 2'b00);
    assign slave_sel  = three_wire | (smode_r == 2'b01 && !seln_s);
    assign sck_rise   = sck_s & ~sck_d_r;
    assign sck_fall   = ~sck_s & sck_d_r;
    assign sel_fall   = seln_d_r & ~seln_s;
    assign fault      = en_r & master_enable_bit_r & (smode_r == 2'b01) & sel_fall;
    assign wr         = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
    assign rd_data    = cyc_i & stb_i & ~we_i & ~ack_o & (adr_i == `SSPM_DATA_OFF);
    assign tick       = (divcnt_r == 8'h00);
    assign byte_end   = (bitcnt_r == 4'(BITS - 1));

    // Edge history of synchronised pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_d_r  <= 1'b0;
            seln_d_r <= 1'b1;
        end else begin
            sck_d_r  <= sck_s;
            seln_d_r <= seln_s;
        end
    end

    // ************************************************************
    // Wishbone slave, one registered ack per request, one cycle after it
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            case (adr_i)
                `SSPM_CTRL_OFF: dat_o <= {24'h0, done_r, master_enable_bit_r, mode_fault_flag_r, 1'b0, smode_r, txfull_r, en_r};
                `SSPM_DATA_OFF: dat_o <= {24'h0, rxbuf_r};
                `SSPM_CFG_OFF:  dat_o <= {24'h0, div_r};
                default:        dat_o <= 32'h0;
            endcase
        end
    end

    // Control register, faults override software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r    <= 1'b0;
            master_enable_bit_r <= 1'b0;
            smode_r <= 2'(`SSPM_CTRL_RST >> `SSPM_SELLO_BIT);
            div_r   <= `SSPM_DIV_RST;
        end else begin
            if (wr && adr_i == `SSPM_CTRL_OFF) begin
                en_r    <= dat_i[`SSPM_EN_BIT];
                master_enable_bit_r <= dat_i[`SSPM_MASTER_ENABLE_BIT_BIT];
                smode_r <= dat_i[`SSPM_SELHI_BIT:`SSPM_SELLO_BIT];
            end
            if (wr && adr_i == `SSPM_CFG_OFF) begin
                div_r <= dat_i[7:0];
            end
            if (fault) begin
                en_r    <= 1'b0;
                master_enable_bit_r <= 1'b0;
            end
        end
    end

    // Sticky flags; hardware set wins over software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_fault_flag_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (wr && adr_i == `SSPM_CTRL_OFF) begin
                if (!dat_i[`SSPM_MODE_FAULT_FLAG_BIT]) mode_fault_flag_r <= 1'b0;
                if (!dat_i[`SSPM_DONE_BIT]) done_r <= 1'b0;
            end
            if (fault) mode_fault_flag_r <= 1'b1;
            // Flag on the last shift edge itself, in the same cycle as the bit counter wraps
            if (en_r && byte_end && (master_enable_bit_r ? (mst_r == SSPM_HIGH && tick) : (slave_sel && sck_fall))) begin
                done_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Master clock divider and state
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || mst_r == SSPM_IDLE) begin
            divcnt_r <= `SSPM_DIV_RST;
        end else if (tick) begin
            divcnt_r <= div_r;
        end else begin
            divcnt_r <= divcnt_r - 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mst_r <= SSPM_IDLE;
            sck_o <= 1'b0;
        end else if (!en_r || !master_enable_bit_r) begin
            mst_r <= SSPM_IDLE;
            sck_o <= 1'b0;
        end else begin
            case (mst_r)
                SSPM_IDLE: if (txfull_r) mst_r <= SSPM_LOW;
                SSPM_LOW: if (tick) begin
                    mst_r <= SSPM_HIGH;
                    sck_o <= 1'b1;
                end
                SSPM_HIGH: if (tick) begin
                    sck_o <= 1'b0;
                    mst_r <= byte_end ? SSPM_IDLE : SSPM_LOW;
                end
                default: mst_r <= SSPM_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Shift register, bit counter, buffers
    // ************************************************************
    logic sh_smp;
    logic sh_out;
    assign sh_smp = en_r & (master_enable_bit_r ? (mst_r == SSPM_LOW && tick) : (slave_sel & sck_rise));
    assign sh_out = en_r & (master_enable_bit_r ? (mst_r == SSPM_HIGH && tick) : (slave_sel & sck_fall));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_r  <= 8'h00;
            bitcnt_r <= 4'h0;
            rxbit_r  <= 1'b0;
            rxbuf_r  <= 8'h00;
            txbuf_r  <= 8'h00;
            txfull_r <= 1'b0;
        end else begin
            if (wr && adr_i == `SSPM_DATA_OFF) begin
                txbuf_r  <= dat_i[7:0];
                txfull_r <= 1'b1;
            end
            if (!en_r || (smode_r == 2'b01 && !master_enable_bit_r && sel_fall)) begin
                bitcnt_r <= 4'h0;
            end
            if (sh_smp) begin
                rxbit_r <= master_enable_bit_r ? miso_s : mosi_s;
            end
            if (txfull_r && bitcnt_r == 4'h0 && mst_r == SSPM_IDLE && !sh_out) begin
                shift_r  <= txbuf_r;
                txfull_r <= 1'b0;
            end
            if (sh_out) begin
                shift_r <= {shift_r[6:0], rxbit_r};
                if (byte_end) begin
                    bitcnt_r <= 4'h0;
                    rxbuf_r  <= {shift_r[6:0], rxbit_r};
                end else begin
                    bitcnt_r <= bitcnt_r + 4'h1;
                end
            end
        end
    end

    // ************************************************************
    // Pin drivers and enables
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mosi_o       <= 1'b0;
            mosi_oe_o    <= 1'b0;
            miso_o       <= 1'b0;
            miso_oe_o    <= 1'b0;
            sck_oe_o     <= 1'b0;
            sel_n_o      <= 1'b1;
            sel_n_oe_o   <= 1'b0;
            sel_routed_o <= 1'b0;
        end else begin
            mosi_o       <= shift_r[7];
            mosi_oe_o    <= en_r & master_enable_bit_r;
            miso_o       <= shift_r[7];
            miso_oe_o    <= en_r & ~master_enable_bit_r & slave_sel;
            sck_oe_o     <= en_r & master_enable_bit_r;
            sel_n_o      <= smode_r[0];
            sel_n_oe_o   <= smode_r[1];
            sel_routed_o <= ~three_wire;
        end
    end
endmodule

// >>> verification/sspm_core_asserts.sv
// Port checker for the serial pin and select-mode block
// Assumes binding to sspm_core; sees only its ports
`timescale 1ns/1ps
module sspm_core_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic mosi_o,
    input wire logic mosi_oe_o,
    input wire logic miso_oe_o,
    input wire logic sck_o,
    input wire logic sck_oe_o,
    input wire logic sel_n_i,
    input wire logic sel_n_o,
    input wire logic sel_n_oe_o,
    input wire logic sel_routed_o
);
    // ****
    // Pin direction, select and bus relations
    // ****
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Roles never drive both data lines; clock follows master role
    oe_role_a: assert property (!(mosi_oe_o && miso_oe_o))
        else $error("both data lines driven");
    clk_dir_a: assert property (sck_oe_o == mosi_oe_o)
        else $error("clock enable differs from master role");
    mosi_hold_a: assert property (sck_oe_o && sck_o && $past(sck_o) |-> $stable(mosi_o))
        else $error("master data moved while clock high");
    sel_route_a: assert property (sel_n_oe_o |-> sel_routed_o)
        else $error("select driven but not routed");
    unsel_float_a: assert property ((sel_routed_o && !sel_n_oe_o && sel_n_i)[*5] |-> !miso_oe_o)
        else $error("unselected slave drives data");
    fault_drop_a: assert property (mosi_oe_o && sel_routed_o && !sel_n_oe_o && $fell(sel_n_i)
        |-> ##[1:8] !mosi_oe_o) else $error("master kept bus after select fell");
    ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no answer one cycle after request");
    rst_out_a: assert property (disable iff (1'b0) rst_i |=> !(mosi_oe_o || miso_oe_o || sck_oe_o
        || sel_n_oe_o || ack_o) && sel_n_o) else $error("outputs not at reset level");
    // Main scenarios reached
    cover property ($rose(sck_o));
    cover property ($rose(miso_oe_o));
    cover property ($fell(mosi_oe_o));
endmodule
bind sspm_core sspm_core_asserts i_sspm_core_asserts (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .mosi_o,
    .mosi_oe_o, .miso_oe_o, .sck_o, .sck_oe_o, .sel_n_i, .sel_n_o, .sel_n_oe_o, .sel_routed_o);

// >>> verification/sspm_far_end.sv
// Far-end party: a serial slave or a serial master, behavioural
// Assumes the bench picks each line level from both parties
`timescale 1ns/1ps
module sspm_far_end
    import sspm_pkg::*;
(
    input  wire logic mosi_i,
    input  wire logic miso_i,
    input  wire logic sck_i,
    output logic      mosi_o = 1'b0,
    output logic      miso_o = 1'b1,
    output logic      sck_o = 1'b0,
    output logic      sel_n_o = 1'b1
);
    // ****
    // Transfers
    // ****
    // Select pin, pulled up when left alone
    task automatic set_sel(input logic v);
        sel_n_o = v;
    endtask

    // Slave: next bit after each fall, sample on rise
    task automatic slave_byte(input sspm_byte_t tx, output sspm_byte_t rx);
        for (int i = 7; i >= 0; i--) begin
            miso_o = tx[i];
            @(posedge sck_i);
            rx[i] = mosi_i;
            @(negedge sck_i);
        end
        miso_o = ~tx[0]; // Driven to the inverse of bit 0: no stale bit
    endtask

    // Master: 320 ns clock only inside the frame
    task automatic mst_byte(input logic sel_lvl, input sspm_byte_t tx, output sspm_byte_t rx);
        sel_n_o = sel_lvl;
        #420; // Half a system clock off its edges, so sampling is race free
        for (int i = 7; i >= 0; i--) begin
            mosi_o = tx[i];
            #160 sck_o = 1'b1;
            rx[i] = miso_i;
            #160 sck_o = 1'b0;
        end
        #200 sel_n_o = 1'b1;
        mosi_o = ~tx[0];
    endtask
endmodule

// >>> verification/tb_sspm_core.sv
// Self-checking bench for the serial pin and select-mode block
// Assumes the far-end model and checker are compiled first
`timescale 1ns/1ps
module tb_sspm_core
    import sspm_pkg::*;
;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [3:0]  adr_i;
    logic [31:0] dat_i, dat_o, q;
    logic        mosi_o, mosi_oe_o, miso_o, miso_oe_o, sck_o, sck_oe_o;
    logic        sel_n_o, sel_n_oe_o, sel_routed_o, f_mosi, f_miso, f_sck, f_sel_n;
    sspm_byte_t  tx, ptx, prx;
    int          seed = 32'h7283;
    int          n_errors = 0;
    int          checks = 0;
    int          exp_q[$];
    // ****
    // Lines, design and far end
    // ****
    wire mosi_w = mosi_oe_o ? mosi_o : f_mosi;
    wire miso_w = miso_oe_o ? miso_o : f_miso;
    wire sck_w = sck_oe_o ? sck_o : f_sck;
    wire sel_w = sel_n_oe_o ? sel_n_o : f_sel_n;
    sspm_core i_sspm_core (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o,
        .ack_o, .mosi_i(mosi_w), .mosi_o, .mosi_oe_o, .miso_i(miso_w), .miso_o, .miso_oe_o, .sck_i(sck_w),
        .sck_o, .sck_oe_o, .sel_n_i(sel_w), .sel_n_o, .sel_n_oe_o, .sel_routed_o);
    sspm_far_end i_sspm_far_end (.mosi_i(mosi_w), .miso_i(miso_w), .sck_i(sck_w),
        .mosi_o(f_mosi), .miso_o(f_miso), .sck_o(f_sck), .sel_n_o(f_sel_n));
    // ****
    // Tasks
    // ****
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // One classic cycle; hold until ack is seen
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        // Look at ack while it stands; the next rising edge is where it is taken
        do begin
            @(negedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        r = dat_o;
        @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
        if (n >= 50) begin
            n_errors++;
            give_verdict();
        end
    endtask

    task automatic wait_done();
        logic [31:0] r;
        int          n;
        r = '0;
        n = 0;
        while (r[7] !== 1'b1 && n < 300) begin
            wb(1'b0, 4'h0, '0, r);
            n++;
        end
        chk("done", 1, r[7]);
        if (n >= 300)
            give_verdict();
    endtask

    // Received byte against the model queue
    task automatic rd_rx();
        logic [31:0] r;
        wb(1'b0, 4'h4, '0, r);
        chk("rx", exp_q.pop_front(), r[7:0]);
    endtask

    // Far end masters one byte, design slave answers
    task automatic slave_xfer(input logic sel_lvl);
        tx = $random(seed);
        ptx = $random(seed);
        wb(1'b1, 4'h4, tx, q);
        exp_q.push_back(ptx);
        i_sspm_far_end.mst_byte(sel_lvl, ptx, prx);
        @(posedge clk_i);
    endtask
    // ****
    // Clock, watchdog and sequence
    // ****
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        n_errors++;
        give_verdict();
    end

    initial begin
        {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 4'h0, '0, q);
        chk("ctrl", 8'h04, q[7:0]);
        wb(1'b0, 4'h8, '0, q);
        chk("div", 8'h01, q[7:0]);
        wb(1'b1, 4'hc, 32'hff, q);
        wb(1'b0, 4'hc, '0, q);
        chk("unmapped", 0, q);
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, 4'h0, 32'h41 | (m << 2), q);
            repeat (2) @(negedge clk_i);
            chk("sel_oe", m[1], sel_n_oe_o);
            if (m[1])
                chk("sel_lvl", m[0], sel_n_o);
            chk("routed", m != 0, sel_routed_o);
            chk("oe", 3'b110, {mosi_oe_o, sck_oe_o, miso_oe_o});
            @(posedge clk_i);
        end
        $display("end reset and modes");
        wb(1'b1, 4'h8, {$random(seed)} % 3 + 3, q);
        wb(1'b1, 4'h0, 32'h41, q);
        repeat (2) begin
            tx = $random(seed);
            ptx = $random(seed);
            exp_q.push_back(ptx);
            fork
                i_sspm_far_end.slave_byte(ptx, prx);
                begin
                    wb(1'b1, 4'h4, tx, q);
                    wait_done();
                end
            join
            chk("mosi_byte", tx, prx);
            rd_rx();
            wb(1'b1, 4'h0, 32'h41, q);
        end
        $display("end master");
        wb(1'b1, 4'h0, 32'h05, q);
        slave_xfer(1'b0);
        wait_done();
        chk("miso_byte", tx, prx);
        rd_rx();
        wb(1'b1, 4'h0, 32'h05, q);
        slave_xfer(1'b1);
        wb(1'b0, 4'h0, '0, q);
        chk("no_done", 0, q[7]);
        void'(exp_q.pop_front());
        wb(1'b1, 4'h0, 32'h01, q);
        slave_xfer(1'b1);
        wait_done();
        chk("miso_3w", tx, prx);
        rd_rx();
        $display("end slave");
        wb(1'b1, 4'h0, 32'h45, q);
        i_sspm_far_end.set_sel(1'b0);
        repeat (8) @(posedge clk_i);
        wb(1'b0, 4'h0, '0, q);
        chk("fault", 3'b010, {q[6:5], q[0]});
        i_sspm_far_end.set_sel(1'b1);
        $display("end fault");
        give_verdict();
    end
endmodule
